// ==== src/cbs_regs.svh ====
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// ------------------------------------------
// flag register bit positions
// ------------------------------------------
`define CBS_FLAG_C 0
`define CBS_FLAG_Z 1
`define CBS_FLAG_N 2
`define CBS_FLAG_V 3
`define CBS_FLAG_S 4
`define CBS_FLAG_H 5
`define CBS_FLAG_T 6
`define CBS_FLAG_I 7

// ------------------------------------------
// reset values
// ------------------------------------------
`define CBS_FLAG_RESET 8'h00
`define CBS_PC_RESET 24'h000000

// ------------------------------------------
// cycle counts
// ------------------------------------------
`define CBS_CYC_ONE 3'h1
`define CBS_CYC_REL_JUMP 3'h2
`define CBS_CYC_PTR_JUMP 3'h2
`define CBS_CYC_ABS_JUMP 3'h3
`define CBS_CYC_REL_CALL 3'h4
`define CBS_CYC_PTR_CALL 3'h4
`define CBS_CYC_ABS_CALL 3'h5
`define CBS_CYC_RETURN 3'h5
`define CBS_CYC_BRANCH_TAKEN 3'h2
`define CBS_CYC_SKIP_ONE_WORD 3'h2
`define CBS_CYC_SKIP_TWO_WORD 3'h3

// ------------------------------------------
// program counter steps
// ------------------------------------------
`define CBS_STEP_ONE 24'h000001
`define CBS_STEP_TWO 24'h000002
`define CBS_STEP_THREE 24'h000003

`endif

// ==== src/cbs_pkg.sv ====
package cbs_pkg;

   // ------------------------------------------
   // operations presented to the unit
   // ------------------------------------------
   typedef enum logic [5:0] {
      cbs_unit_step,
      cbs_relative_jump,
      cbs_pointer_jump,
      cbs_far_pointer_jump,
      cbs_absolute_jump,
      cbs_relative_call,
      cbs_pointer_call,
      cbs_far_pointer_call,
      cbs_absolute_call,
      cbs_subroutine_return,
      cbs_interrupt_return,
      cbs_compare_skip_equal,
      cbs_compare_regs,
      cbs_compare_regs_with_borrow,
      cbs_compare_immediate,
      cbs_skip_reg_bit_zero,
      cbs_skip_reg_bit_one,
      cbs_skip_io_bit_zero,
      cbs_skip_io_bit_one,
      cbs_branch_flag_one,
      cbs_branch_flag_zero,
      cbs_branch_equal,
      cbs_branch_not_equal,
      cbs_branch_carry_one,
      cbs_branch_carry_zero,
      cbs_branch_same_higher,
      cbs_branch_lower,
      cbs_branch_negative,
      cbs_branch_positive,
      cbs_branch_signed_ge,
      cbs_branch_signed_lt,
      cbs_branch_halfcarry_one,
      cbs_branch_halfcarry_zero,
      cbs_branch_transfer_one,
      cbs_branch_transfer_zero,
      cbs_branch_overflow_one,
      cbs_branch_overflow_zero,
      cbs_branch_irq_enabled,
      cbs_branch_irq_disabled
   } cbs_op_e;

   typedef enum logic [1:0] {
      cbs_idle = 2'h1,
      cbs_wait = 2'h2
   } cbs_state_e;

endpackage

// ==== src/cbs_exec_if.sv ====
`timescale 1ns/1ps
interface cbs_exec_if;
   import cbs_pkg::*;
   cbs_op_e op;
   logic [7:0] rd;
   logic [7:0] rr;
   logic [2:0] bit_sel;
   logic [7:0] io_val;
   logic [7:0] flags;
   logic take;
   logic [7:0] cmp_flags;

   modport core (output op, rd, rr, bit_sel, io_val, flags, input take, cmp_flags);
   modport cond (input op, rd, rr, bit_sel, io_val, flags, output take);
   modport cmp (input op, rd, rr, flags, output cmp_flags);
endinterface

// ==== src/cbs_cond_eval.sv ====
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_cond_eval (
   // operands and flags
   cbs_exec_if.cond bus
);
   import cbs_pkg::*;

   always_comb begin
      bus.take = 1'b0;
      case (bus.op)
         cbs_compare_skip_equal: bus.take = (bus.rd == bus.rr);
         cbs_skip_reg_bit_zero: bus.take = ~bus.rr[bus.bit_sel];
         cbs_skip_reg_bit_one: bus.take = bus.rr[bus.bit_sel];
         cbs_skip_io_bit_zero: bus.take = ~bus.io_val[bus.bit_sel];
         cbs_skip_io_bit_one: bus.take = bus.io_val[bus.bit_sel];
         cbs_branch_flag_one: bus.take = bus.flags[bus.bit_sel];
         cbs_branch_flag_zero: bus.take = ~bus.flags[bus.bit_sel];
         cbs_branch_equal: bus.take = bus.flags[`CBS_FLAG_Z];
         cbs_branch_not_equal: bus.take = ~bus.flags[`CBS_FLAG_Z];
         cbs_branch_carry_one,
         cbs_branch_lower: bus.take = bus.flags[`CBS_FLAG_C];
         cbs_branch_carry_zero,
         cbs_branch_same_higher: bus.take = ~bus.flags[`CBS_FLAG_C];
         cbs_branch_negative: bus.take = bus.flags[`CBS_FLAG_N];
         cbs_branch_positive: bus.take = ~bus.flags[`CBS_FLAG_N];
         cbs_branch_signed_ge:
            bus.take = ~(bus.flags[`CBS_FLAG_N] ^ bus.flags[`CBS_FLAG_V]);
         // complement of the ge test, not a copy of it
         cbs_branch_signed_lt:
            bus.take = bus.flags[`CBS_FLAG_N] ^ bus.flags[`CBS_FLAG_V];
         cbs_branch_halfcarry_one: bus.take = bus.flags[`CBS_FLAG_H];
         cbs_branch_halfcarry_zero: bus.take = ~bus.flags[`CBS_FLAG_H];
         cbs_branch_transfer_one: bus.take = bus.flags[`CBS_FLAG_T];
         cbs_branch_transfer_zero: bus.take = ~bus.flags[`CBS_FLAG_T];
         cbs_branch_overflow_one: bus.take = bus.flags[`CBS_FLAG_V];
         cbs_branch_overflow_zero: bus.take = ~bus.flags[`CBS_FLAG_V];
         cbs_branch_irq_enabled: bus.take = bus.flags[`CBS_FLAG_I];
         cbs_branch_irq_disabled: bus.take = ~bus.flags[`CBS_FLAG_I];
         default: bus.take = 1'b0;
      endcase
   end
endmodule

// ==== src/cbs_compare.sv ====
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_compare (
   // operands and flags
   cbs_exec_if.cmp bus
);
   import cbs_pkg::*;

   logic borrow_in;
   logic [7:0] diff;
   logic d7, r7, s7;
   logic zero_keep;

   // difference only; nothing is written back
   always_comb begin
      borrow_in = (bus.op == cbs_compare_regs_with_borrow) & bus.flags[`CBS_FLAG_C];
      diff = bus.rd - bus.rr - {7'h00, borrow_in};
      d7 = bus.rd[7];
      r7 = bus.rr[7];
      s7 = diff[7];
      // with borrow, zero can only stay set so multi-byte compares chain
      zero_keep = (bus.op == cbs_compare_regs_with_borrow) ? bus.flags[`CBS_FLAG_Z] : 1'b1;
      bus.cmp_flags = bus.flags;
      bus.cmp_flags[`CBS_FLAG_Z] = (diff == 8'h00) & zero_keep;
      bus.cmp_flags[`CBS_FLAG_N] = s7;
      bus.cmp_flags[`CBS_FLAG_V] = (d7 & ~r7 & ~s7) | (~d7 & r7 & s7);
      bus.cmp_flags[`CBS_FLAG_S] = s7 ^ ((d7 & ~r7 & ~s7) | (~d7 & r7 & s7));
      bus.cmp_flags[`CBS_FLAG_C] = (~d7 & r7) | (r7 & s7) | (s7 & ~d7);
      bus.cmp_flags[`CBS_FLAG_H] = (~bus.rd[3] & bus.rr[3]) | (bus.rr[3] & diff[3])
         | (diff[3] & ~bus.rd[3]);
   end
endmodule

// ==== src/cbs_branch_skip_unit.sv ====
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_branch_skip_unit #(
   parameter int PC_W = 22
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // instruction request
   input wire logic op_valid,
   input wire cbs_pkg::cbs_op_e op,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rr_val,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] io_val,
   input wire logic [11:0] rel_offset,
   input wire logic [PC_W-1:0] abs_target,
   input wire logic next_two_word,
   // core state
   input wire logic [15:0] z_pointer,
   input wire logic [7:0] far_jump_page,
   input wire logic [PC_W-1:0] stack_addr,
   input wire logic flag_wr,
   input wire logic [7:0] flag_wdata,
   // results
   output logic [PC_W-1:0] pc,
   output logic [7:0] flag_register,
   output logic busy,
   output logic done,
   // stack requests
   output logic push_valid,
   output logic [PC_W-1:0] push_addr,
   output logic pop_valid
);
   import cbs_pkg::*;

   // ------------------------------------------
   // parameter check
   // ------------------------------------------
   generate
      // pointer targets need at least 16 pc bits
      if (PC_W < 16) begin : g_narrow_pc
         $error("cbs_branch_skip_unit: PC_W below 16 cannot hold a pointer target");
      end
      // page byte above the pointer gives at most 24 bits
      if (PC_W > 24) begin : g_wide_pc
         $error("cbs_branch_skip_unit: PC_W above 24 exceeds page and pointer");
      end
   endgenerate

   // ------------------------------------------
   // declarations
   // ------------------------------------------
   cbs_state_e state;
   logic [2:0] cnt;
   logic [PC_W-1:0] tgt_q;
   logic set_irq_q;
   logic accept;
   logic [PC_W-1:0] next_tgt;
   logic [2:0] next_cyc;
   logic next_push;
   logic next_pop;
   logic next_cmp;
   logic next_set_irq;
   logic [PC_W-1:0] link_addr;
   logic [PC_W-1:0] pc_one;
   logic [PC_W-1:0] pc_two;
   logic [PC_W-1:0] pc_skip;
   logic [PC_W-1:0] pc_rel;
   logic [PC_W-1:0] far_ptr;
   logic [PC_W-1:0] near_ptr;
   logic [PC_W-1:0] rel_ext;
   logic [23:0] far_full;
   logic [2:0] skip_cyc;

   cbs_exec_if exec ();

   // ------------------------------------------
   // condition and compare helpers
   // ------------------------------------------
   assign exec.op = op;
   assign exec.rd = rd_val;
   assign exec.rr = rr_val;
   assign exec.bit_sel = bit_sel;
   assign exec.io_val = io_val;
   assign exec.flags = flag_register;

   cbs_cond_eval u_cond (
      .bus(exec.cond)
   );

   cbs_compare u_cmp (
      .bus(exec.cmp)
   );

   // ------------------------------------------
   // address arithmetic
   // ------------------------------------------
   // offsets wrap modulo the pc width, as the core's program space does
   assign rel_ext = PC_W'({{12{rel_offset[11]}}, rel_offset});
   assign pc_one = pc + PC_W'(`CBS_STEP_ONE);
   assign pc_two = pc + PC_W'(`CBS_STEP_TWO);
   assign pc_rel = pc + rel_ext + PC_W'(`CBS_STEP_ONE);
   // pointer forms zero-extend; far forms put the page byte on top
   assign near_ptr = PC_W'({8'h00, z_pointer});
   assign far_full = {far_jump_page, z_pointer};
   // page bits above the pc width are dropped, matching a smaller program space
   assign far_ptr = far_full[PC_W-1:0];

   // skip length follows the size of the instruction being passed over
   assign pc_skip = next_two_word ? pc + PC_W'(`CBS_STEP_THREE) : pc_two;
   assign skip_cyc = next_two_word ? `CBS_CYC_SKIP_TWO_WORD : `CBS_CYC_SKIP_ONE_WORD;

   // a request while busy is dropped; the core holds it until done
   assign accept = op_valid & (state == cbs_idle);

   // ------------------------------------------
   // target and cycle selection
   // ------------------------------------------
   always_comb begin
      next_tgt = pc_one;
      next_cyc = `CBS_CYC_ONE;
      next_push = 1'b0;
      next_pop = 1'b0;
      next_cmp = 1'b0;
      next_set_irq = 1'b0;
      link_addr = pc_one;
      case (op)
         cbs_relative_jump: begin
            next_tgt = pc_rel;
            next_cyc = `CBS_CYC_REL_JUMP;
         end
         cbs_pointer_jump: begin
            next_tgt = near_ptr;
            next_cyc = `CBS_CYC_PTR_JUMP;
         end
         cbs_far_pointer_jump: begin
            next_tgt = far_ptr;
            next_cyc = `CBS_CYC_PTR_JUMP;
         end
         cbs_absolute_jump: begin
            next_tgt = abs_target;
            next_cyc = `CBS_CYC_ABS_JUMP;
         end
         cbs_relative_call: begin
            next_tgt = pc_rel;
            next_cyc = `CBS_CYC_REL_CALL;
            next_push = 1'b1;
         end
         cbs_pointer_call: begin
            next_tgt = near_ptr;
            next_cyc = `CBS_CYC_PTR_CALL;
            next_push = 1'b1;
         end
         cbs_far_pointer_call: begin
            next_tgt = far_ptr;
            next_cyc = `CBS_CYC_PTR_CALL;
            next_push = 1'b1;
         end
         cbs_absolute_call: begin
            // two-word call returns past its own second word
            next_tgt = abs_target;
            next_cyc = `CBS_CYC_ABS_CALL;
            next_push = 1'b1;
            link_addr = pc_two;
         end
         cbs_subroutine_return: begin
            next_tgt = stack_addr;
            next_cyc = `CBS_CYC_RETURN;
            next_pop = 1'b1;
         end
         cbs_interrupt_return: begin
            next_tgt = stack_addr;
            next_cyc = `CBS_CYC_RETURN;
            next_pop = 1'b1;
            next_set_irq = 1'b1;
         end
         cbs_compare_regs,
         cbs_compare_regs_with_borrow,
         cbs_compare_immediate: begin
            next_cmp = 1'b1;
         end
         cbs_compare_skip_equal,
         cbs_skip_reg_bit_zero,
         cbs_skip_reg_bit_one,
         cbs_skip_io_bit_zero,
         cbs_skip_io_bit_one: begin
            if (exec.take) begin
               next_tgt = pc_skip;
               next_cyc = skip_cyc;
            end
         end
         cbs_branch_flag_one,
         cbs_branch_flag_zero,
         cbs_branch_equal,
         cbs_branch_not_equal,
         cbs_branch_carry_one,
         cbs_branch_carry_zero,
         cbs_branch_same_higher,
         cbs_branch_lower,
         cbs_branch_negative,
         cbs_branch_positive,
         cbs_branch_signed_ge,
         cbs_branch_signed_lt,
         cbs_branch_halfcarry_one,
         cbs_branch_halfcarry_zero,
         cbs_branch_transfer_one,
         cbs_branch_transfer_zero,
         cbs_branch_overflow_one,
         cbs_branch_overflow_zero,
         cbs_branch_irq_enabled,
         cbs_branch_irq_disabled: begin
            if (exec.take) begin
               next_tgt = pc_rel;
               next_cyc = `CBS_CYC_BRANCH_TAKEN;
            end
         end
         default: begin
            next_tgt = pc_one;
         end
      endcase
   end

   // ------------------------------------------
   // sequencing
   // ------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= cbs_idle;
         cnt <= 3'h0;
         tgt_q <= '0;
         set_irq_q <= 1'b0;
         busy <= 1'b0;
      end else begin
         case (state)
            cbs_idle: begin
               if (accept && next_cyc != `CBS_CYC_ONE) begin
                  state <= cbs_wait;
                  cnt <= next_cyc - `CBS_CYC_ONE;
                  tgt_q <= next_tgt;
                  set_irq_q <= next_set_irq;
                  busy <= 1'b1;
               end
            end
            cbs_wait: begin
               // count down to the completion edge; done rises on the last one
               cnt <= cnt - `CBS_CYC_ONE;
               if (cnt == `CBS_CYC_ONE) begin
                  state <= cbs_idle;
                  busy <= 1'b0;
                  set_irq_q <= 1'b0;
               end
            end
            // an illegal state code falls back to idle with nothing pending
            default: begin
               state <= cbs_idle;
               cnt <= 3'h0;
               set_irq_q <= 1'b0;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------
   // program counter and completion
   // ------------------------------------------
   // pc and done move on one edge, so the core sees a single completion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= PC_W'(`CBS_PC_RESET);
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (accept && next_cyc == `CBS_CYC_ONE) begin
            pc <= next_tgt;
            done <= 1'b1;
         end else if (state == cbs_wait && cnt == `CBS_CYC_ONE) begin
            pc <= tgt_q;
            done <= 1'b1;
         end
      end
   end

   // ------------------------------------------
   // flag register
   // ------------------------------------------
   // own updates win over a core write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_register <= `CBS_FLAG_RESET;
      end else if (state == cbs_wait && cnt == `CBS_CYC_ONE && set_irq_q) begin
         flag_register[`CBS_FLAG_I] <= 1'b1;
      end else if (accept && next_cmp) begin
         flag_register <= exec.cmp_flags;
      end else if (flag_wr) begin
         flag_register <= flag_wdata;
      end
   end

   // ------------------------------------------
   // stack requests
   // ------------------------------------------
   // one-cycle strobes only; the core's stack does the memory access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         push_valid <= 1'b0;
         push_addr <= '0;
         pop_valid <= 1'b0;
      end else begin
         push_valid <= accept & next_push;
         pop_valid <= accept & next_pop;
         if (accept && next_push) begin
            push_addr <= link_addr;
         end
      end
   end

endmodule

// ==== verif/cbs_branch_skip_unit_checker.sv ====
`timescale 1ns/1ps
module cbs_branch_skip_unit_checker
#(
   parameter int PC_W = 22
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request
   input wire logic op_valid,
   input wire cbs_pkg::cbs_op_e op,
   input wire logic [7:0] rr_val,
   input wire logic [2:0] bit_sel,
   input wire logic [11:0] rel_offset,
   input wire logic [PC_W-1:0] abs_target,
   input wire logic next_two_word,
   input wire logic [15:0] z_pointer,
   input wire logic [7:0] far_jump_page,
   input wire logic [PC_W-1:0] stack_addr,
   input wire logic flag_wr,
   // results
   input wire logic [PC_W-1:0] pc,
   input wire logic [7:0] flag_register,
   input wire logic busy,
   input wire logic done,
   input wire logic push_valid,
   input wire logic [PC_W-1:0] push_addr,
   input wire logic pop_valid
);
   import cbs_pkg::*;
   // ------------------------------------------
   // helpers
   // ------------------------------------------
   logic acc;
   logic [PC_W-1:0] rel_tgt;
   // a request while busy is dropped silently, so only idle edges count
   assign acc = op_valid && !busy;
   assign rel_tgt = pc + PC_W'(signed'(rel_offset)) + PC_W'(1);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------
   // assertions
   // ------------------------------------------
   chk_far_ptr_jump: assert property (
      acc && op == cbs_far_pointer_jump |=> busy ##1
      done && pc == PC_W'({$past(far_jump_page, 2), $past(z_pointer, 2)}))
      else $error("far pointer jump target or timing wrong");
   chk_ptr_call_time: assert property (
      acc && op == cbs_pointer_call |=> push_valid && !done ##1 !done[*2] ##1 done)
      else $error("pointer call timing wrong");
   chk_call_push_addr: assert property (
      acc && op == cbs_relative_call |=> push_valid && push_addr == $past(pc) + PC_W'(1))
      else $error("relative call return address wrong");
   chk_irq_return_i: assert property (
      acc && op == cbs_interrupt_return |=> pop_valid ##4
      done && flag_register[7] && pc == $past(stack_addr, 5))
      else $error("interrupt return wrong");
   chk_cmp_single: assert property (
      acc && op inside {cbs_compare_regs, cbs_compare_regs_with_borrow, cbs_compare_immediate}
      |=> done && !busy)
      else $error("compare not single cycle");
   chk_skip_two_word: assert property (
      acc && op == cbs_skip_reg_bit_one && rr_val[bit_sel] && next_two_word
      |=> busy[*2] ##1 done && pc == $past(pc, 3) + PC_W'(3))
      else $error("two word skip wrong");
   chk_branch_taken: assert property (
      acc && op == cbs_branch_equal && flag_register[1] |=> busy ##1
      done && pc == $past(rel_tgt, 2))
      else $error("taken branch wrong");
   chk_branch_not_taken: assert property (
      acc && op == cbs_branch_not_equal && flag_register[1] |=> done && pc == $past(pc) + PC_W'(1))
      else $error("untaken branch wrong");
   chk_irq_flags_kept: assert property (
      acc && op == cbs_branch_irq_disabled && !flag_wr |=> $stable(flag_register))
      else $error("flags changed by branch");
   chk_abs_jump: assert property (
      acc && op == cbs_absolute_jump |=> busy[*2] ##1 done && pc == $past(abs_target, 3))
      else $error("absolute jump wrong");
   // ------------------------------------------
   // covers
   // ------------------------------------------
   cover property (acc && op == cbs_far_pointer_call);
   cover property (op_valid && busy);
   cover property (acc && op == cbs_branch_signed_lt);
endmodule

// ==== verif/test_cbs_branch_skip_unit.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_cbs_branch_skip_unit;
   import cbs_pkg::*;
   localparam int PC_W = 22;
   // ------------------------------------------
   // signals
   // ------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0;
   cbs_op_e op = cbs_unit_step;
   logic [7:0] rd_val = 8'h00, rr_val = 8'h00, io_val = 8'h00;
   logic [7:0] far_jump_page = 8'h00, flag_wdata = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [11:0] rel_offset = 12'h000;
   logic [PC_W-1:0] abs_target = '0, stack_addr = '0;
   logic next_two_word = 1'b0, flag_wr = 1'b0;
   logic [15:0] z_pointer = 16'h0000;
   logic [PC_W-1:0] pc, push_addr, m_pc;
   logic [7:0] flag_register, m_fl;
   logic busy, done, push_valid, pop_valid;
   logic [PC_W+7:0] exp_q[$];
   logic [PC_W+7:0] exp_v;
   int fail_count = 0;
   int check_count = 0;

   always #20 clk = ~clk;

   cbs_branch_skip_unit #(.PC_W(PC_W)) DUT (
      .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .rd_val(rd_val),
      .rr_val(rr_val), .bit_sel(bit_sel), .io_val(io_val), .rel_offset(rel_offset),
      .abs_target(abs_target), .next_two_word(next_two_word), .z_pointer(z_pointer),
      .far_jump_page(far_jump_page), .stack_addr(stack_addr), .flag_wr(flag_wr),
      .flag_wdata(flag_wdata), .pc(pc), .flag_register(flag_register), .busy(busy),
      .done(done), .push_valid(push_valid), .push_addr(push_addr), .pop_valid(pop_valid)
   );
   // ------------------------------------------
   // reference model
   // ------------------------------------------
   function automatic logic [7:0] cmp_fl(logic [7:0] a, logic [7:0] b, logic ci, logic zk,
      logic [7:0] f);
      logic [7:0] r;
      logic [7:0] o;
      r = a - b - 8'(ci);
      o = f;
      o[5] = (!a[3] & b[3]) | (b[3] & r[3]) | (r[3] & !a[3]);
      o[3] = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
      o[2] = r[7];
      o[1] = (r == 8'h00) & zk;
      o[0] = (!a[7] & b[7]) | (b[7] & r[7]) | (r[7] & !a[7]);
      o[4] = o[2] ^ o[3];
      return o;
   endfunction

   task automatic model(input cbs_op_e o, output logic [PC_W-1:0] npc,
      output logic [7:0] nfl, output int cyc);
      logic tk;
      logic [PC_W-1:0] rel;
      logic brw;
      rel = m_pc + PC_W'(signed'(rel_offset)) + PC_W'(1);
      brw = o == cbs_compare_regs_with_borrow;
      npc = m_pc + PC_W'(1);
      nfl = m_fl;
      cyc = 1;
      case (o)
         cbs_relative_jump, cbs_relative_call: npc = rel;
         cbs_pointer_jump, cbs_pointer_call: npc = PC_W'(z_pointer);
         cbs_far_pointer_jump, cbs_far_pointer_call: npc = PC_W'({far_jump_page, z_pointer});
         cbs_absolute_jump, cbs_absolute_call: npc = abs_target;
         cbs_subroutine_return, cbs_interrupt_return: npc = stack_addr;
         default: ;
      endcase
      case (o)
         cbs_relative_jump, cbs_pointer_jump, cbs_far_pointer_jump: cyc = 2;
         cbs_absolute_jump: cyc = 3;
         cbs_relative_call, cbs_pointer_call, cbs_far_pointer_call: cyc = 4;
         cbs_absolute_call, cbs_subroutine_return, cbs_interrupt_return: cyc = 5;
         default: ;
      endcase
      if (o == cbs_interrupt_return) nfl[7] = 1'b1;
      if (o inside {cbs_compare_regs, cbs_compare_regs_with_borrow, cbs_compare_immediate})
         nfl = cmp_fl(rd_val, rr_val, brw & m_fl[0], !brw | m_fl[1], m_fl);
      case (o)
         cbs_compare_skip_equal: tk = rd_val == rr_val;
         cbs_skip_reg_bit_zero: tk = !rr_val[bit_sel];
         cbs_skip_reg_bit_one: tk = rr_val[bit_sel];
         cbs_skip_io_bit_zero: tk = !io_val[bit_sel];
         cbs_skip_io_bit_one: tk = io_val[bit_sel];
         cbs_branch_flag_one: tk = m_fl[bit_sel];
         cbs_branch_flag_zero: tk = !m_fl[bit_sel];
         cbs_branch_equal: tk = m_fl[1];
         cbs_branch_not_equal: tk = !m_fl[1];
         cbs_branch_carry_one, cbs_branch_lower: tk = m_fl[0];
         cbs_branch_carry_zero, cbs_branch_same_higher: tk = !m_fl[0];
         cbs_branch_negative: tk = m_fl[2];
         cbs_branch_positive: tk = !m_fl[2];
         cbs_branch_signed_ge: tk = !(m_fl[2] ^ m_fl[3]);
         cbs_branch_signed_lt: tk = m_fl[2] ^ m_fl[3];
         cbs_branch_halfcarry_one: tk = m_fl[5];
         cbs_branch_halfcarry_zero: tk = !m_fl[5];
         cbs_branch_transfer_one: tk = m_fl[6];
         cbs_branch_transfer_zero: tk = !m_fl[6];
         cbs_branch_overflow_one: tk = m_fl[3];
         cbs_branch_overflow_zero: tk = !m_fl[3];
         cbs_branch_irq_enabled: tk = m_fl[7];
         cbs_branch_irq_disabled: tk = !m_fl[7];
         default: tk = 1'b0;
      endcase
      if (tk && o >= cbs_branch_flag_one) begin
         npc = rel;
         cyc = 2;
      end else if (tk) begin
         npc = m_pc + (next_two_word ? PC_W'(3) : PC_W'(2));
         cyc = next_two_word ? 3 : 2;
      end
   endtask
   // ------------------------------------------
   // closing
   // ------------------------------------------
   task automatic end_sim();
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------------------
   // result watcher
   // ------------------------------------------
   always @(posedge clk) begin
      #1;
      if (done === 1'b1 && exp_q.size() == 0) begin
         `CHK(done, 1'b0)
      end else if (done === 1'b1) begin
         exp_v = exp_q.pop_front();
         `CHK({pc, flag_register}, exp_v)
      end
   end
   // ------------------------------------------
   // stimulus
   // ------------------------------------------
   initial begin
      cbs_op_e o;
      logic [PC_W-1:0] npc;
      logic [7:0] nfl;
      int cyc;
      int n;
      void'($urandom(32'h8ccd47d1));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      m_pc = '0;
      m_fl = 8'h00;
      repeat (700) begin
         if ($urandom_range(0, 3) == 0) begin
            op_valid = 1'b0;
            flag_wr = 1'b1;
            flag_wdata = 8'($urandom);
            m_fl = flag_wdata;
            @(negedge clk);
            flag_wr = 1'b0;
         end
         rd_val = 8'($urandom);
         rr_val = $urandom_range(0, 1) ? rd_val : 8'($urandom);
         bit_sel = 3'($urandom);
         io_val = 8'($urandom);
         rel_offset = 12'($urandom);
         abs_target = PC_W'($urandom);
         next_two_word = 1'($urandom);
         z_pointer = 16'($urandom);
         far_jump_page = 8'($urandom);
         stack_addr = PC_W'($urandom);
         o = cbs_op_e'($urandom_range(0, 38));
         model(o, npc, nfl, cyc);
         exp_q.push_back({npc, nfl});
         op = o;
         op_valid = 1'b1;
         @(negedge clk);
         // a stray request while busy must be ignored
         if (cyc > 1) begin
            op = cbs_absolute_jump;
            op_valid = cyc > 2;
         end
         n = 1;
         while (done !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
            if (n == 2 && cyc > 2) op_valid = 1'b0;
         end
         `CHK(n, cyc)
         m_pc = npc;
         m_fl = nfl;
      end
      end_sim();
   end
   // ------------------------------------------
   // watchdog
   // ------------------------------------------
   initial begin
      #500000;
      fail_count++;
      end_sim();
   end
endmodule

bind cbs_branch_skip_unit cbs_branch_skip_unit_checker #(.PC_W(PC_W)) u_chk (
   .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .rr_val(rr_val),
   .bit_sel(bit_sel), .rel_offset(rel_offset), .abs_target(abs_target),
   .next_two_word(next_two_word), .z_pointer(z_pointer), .far_jump_page(far_jump_page),
   .stack_addr(stack_addr), .flag_wr(flag_wr), .pc(pc), .flag_register(flag_register),
   .busy(busy), .done(done), .push_valid(push_valid), .push_addr(push_addr),
   .pop_valid(pop_valid)
);
